// ===== inc/cbe_pkg.sv
package cbe_pkg;

  localparam int CBE_PC_W  = 16;
  localparam int CBE_OFS_W = 7;
  localparam int CBE_CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] CBE_ADR_CTRL   = 8'h00;
  localparam logic [7:0] CBE_ADR_STATUS = 8'h04;
  localparam logic [7:0] CBE_ADR_LASTPC = 8'h08;
  localparam logic [7:0] CBE_ADR_COUNT  = 8'h0C;

  // field positions
  localparam int CBE_CTRL_EN_BIT      = 0;
  localparam int CBE_STAT_BUSY_BIT    = 0;
  localparam int CBE_STAT_TAKEN_BIT   = 1;

  // reset values
  localparam logic CBE_CTRL_EN_RST = 1'b1;

  // flag vector layout: {t, h, v, n, c}
  localparam int CBE_FLAG_W = 5;
  localparam int CBE_FLG_C  = 0;
  localparam int CBE_FLG_N  = 1;
  localparam int CBE_FLG_V  = 2;
  localparam int CBE_FLG_H  = 3;
  localparam int CBE_FLG_T  = 4;

  typedef enum logic [2:0] {
    CBE_OP_MINUS     = 3'h0,
    CBE_OP_PLUS      = 3'h1,
    CBE_OP_SGE       = 3'h2,
    CBE_OP_SLT       = 3'h3,
    CBE_OP_HALF_SET  = 3'h4,
    CBE_OP_HALF_CLR  = 3'h5,
    CBE_OP_XFER_SET  = 3'h6,
    CBE_OP_LOWER     = 3'h7
  } cbe_op_t;

  typedef enum logic [1:0] {
    CBE_ST_IDLE  = 2'b01,
    CBE_ST_TAKEN = 2'b10
  } cbe_state_t;

endpackage

// ===== hdl/cbe_cond_eval.sv
`timescale 1ns/10ps
module cbe_cond_eval
  import cbe_pkg::*;
#(
  parameter int PC_W  = CBE_PC_W,
  parameter int OFS_W = CBE_OFS_W
) (
  input  wire logic [2:0]            op,
  input  wire logic [CBE_FLAG_W-1:0] flags,
  input  wire logic [PC_W-1:0]       pc_cur,
  input  wire logic [OFS_W-1:0]      offset,
  output logic                       taken,
  output logic [PC_W-1:0]            target,
  output logic [PC_W-1:0]            seq_pc
);

  logic [PC_W-1:0] offset_ext;

  always_comb begin
    case (cbe_op_t'(op))
      CBE_OP_MINUS:    taken = flags[CBE_FLG_N];
      CBE_OP_PLUS:     taken = ~flags[CBE_FLG_N];
      CBE_OP_SGE:      taken = ~(flags[CBE_FLG_N] ^ flags[CBE_FLG_V]);
      CBE_OP_SLT:      taken = flags[CBE_FLG_N] ^ flags[CBE_FLG_V];
      CBE_OP_HALF_SET: taken = flags[CBE_FLG_H];
      CBE_OP_HALF_CLR: taken = ~flags[CBE_FLG_H];
      CBE_OP_XFER_SET: taken = flags[CBE_FLG_T];
      default:         taken = flags[CBE_FLG_C];
    endcase
  end

  assign offset_ext = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};
  assign target     = PC_W'(pc_cur + offset_ext + 1'b1);
  assign seq_pc     = PC_W'(pc_cur + 1'b1);

endmodule

// ===== hdl/cbe_branch_unit.sv
// Summary of operation
// - branch_if_minus loads pc plus offset plus one when the negative flag is 1, else advances.
// - branch_if_plus takes the relative branch only when the negative flag is 0.
// - branch_signed_greater_equal branches when negative xor overflow is 0.
// - branch_signed_less_than branches when negative xor overflow is 1.
// - branch_half_carry_set branches when the half carry flag is 1.
// - branch_half_carry_clear branches when the half carry flag is 0.
// - branch_transfer_bit_set branches when the transfer flag is 1.
// - these branches leave every flag unchanged and take one cycle untaken, two taken.
// - branch_if_lower branches when the carry flag is 1, like branch on carry set.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module cbe_branch_unit
  import cbe_pkg::*;
#(
  parameter int PC_W  = CBE_PC_W,
  parameter int OFS_W = CBE_OFS_W,
  parameter int CNT_W = CBE_CNT_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic                       wb_ack_o,
  input  wire logic                  br_req,
  input  wire logic [2:0]            br_op,
  input  wire logic [OFS_W-1:0]      br_offset,
  input  wire logic [PC_W-1:0]       pc_cur,
  input  wire logic                  flag_c,
  input  wire logic                  flag_n,
  input  wire logic                  flag_v,
  input  wire logic                  flag_h,
  input  wire logic                  flag_t,
  output logic                       br_busy,
  output logic                       pc_load,
  output logic [PC_W-1:0]            pc_value,
  output logic [CBE_FLAG_W-1:0]      flags_out
);

  typedef struct packed {
    cbe_state_t            state;
    logic                  ack;
    logic [31:0]           dat;
    logic                  enable;
    logic                  busy;
    logic                  load;
    logic [PC_W-1:0]       pc_value;
    logic [PC_W-1:0]       target;
    logic [PC_W-1:0]       last_pc;
    logic                  last_taken;
    logic [CNT_W-1:0]      count;
    logic [CBE_FLAG_W-1:0] flags;
  } cbe_regs_t;

  cbe_regs_t                 r;
  cbe_regs_t                 next_r;
  logic [CBE_FLAG_W-1:0]     flags_in;
  logic                      cond_taken;
  logic [PC_W-1:0]           cond_target;
  logic [PC_W-1:0]           cond_seq;
  logic                      bus_req;
  logic                      bus_wr;
  logic                      count_inc;
  logic [3:0]                reg_hit;
  logic [31:0]               rd_word;

  // one-hot register select: bit 0 ctrl, 1 status, 2 last pc, 3 count
  function automatic logic [3:0] reg_decode(input logic [7:0] adr);
    logic [3:0] hit;
    hit = 4'h0;
    if (adr == CBE_ADR_CTRL) begin
      hit[0] = 1'b1;
    end else if (adr == CBE_ADR_STATUS) begin
      hit[1] = 1'b1;
    end else if (adr == CBE_ADR_LASTPC) begin
      hit[2] = 1'b1;
    end else if (adr == CBE_ADR_COUNT) begin
      hit[3] = 1'b1;
    end
    return hit;
  endfunction

  assign flags_in = {flag_t, flag_h, flag_v, flag_n, flag_c};

  cbe_cond_eval #(
    .PC_W  (PC_W),
    .OFS_W (OFS_W)
  ) i_cbe_cond_eval (
    .op     (br_op),
    .flags  (flags_in),
    .pc_cur (pc_cur),
    .offset (br_offset),
    .taken  (cond_taken),
    .target (cond_target),
    .seq_pc (cond_seq)
  );

  assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
  assign bus_wr  = bus_req & wb_we_i;
  assign reg_hit = reg_decode(wb_adr_i);

  always_comb begin
    next_r    = r;
    next_r.load = 1'b0;
    next_r.ack  = bus_req;
    count_inc = 1'b0;

    case (r.state)
      CBE_ST_IDLE: begin
        if (br_req) begin
          next_r.flags = flags_in;
          // enable low forces the sequential path
          if (r.enable && cond_taken) begin
            next_r.state  = CBE_ST_TAKEN;
            next_r.busy   = 1'b1;
            next_r.target = cond_target;
          end else begin
            next_r.load       = 1'b1;
            next_r.pc_value   = cond_seq;
            next_r.last_pc    = cond_seq;
            next_r.last_taken = 1'b0;
          end
        end
      end
      // a request in this cycle is dropped while br_busy is high
      CBE_ST_TAKEN: begin
        next_r.state      = CBE_ST_IDLE;
        next_r.busy       = 1'b0;
        next_r.load       = 1'b1;
        next_r.pc_value   = r.target;
        next_r.last_pc    = r.target;
        next_r.last_taken = 1'b1;
        count_inc         = 1'b1;
      end
      default: begin
        next_r.state = CBE_ST_IDLE;
        next_r.busy  = 1'b0;
      end
    endcase

    // register writes; status and last pc ignore writes
    if (bus_wr) begin
      if (reg_hit[0]) begin
        if (wb_sel_i[0]) begin
          next_r.enable = wb_dat_i[CBE_CTRL_EN_BIT];
        end
      end else if (reg_hit[3]) begin
        next_r.count = '0;
      end
    end
    // a taken branch finishing with a clear still counts
    if (count_inc) begin
      next_r.count = (bus_wr && reg_hit[3]) ? CNT_W'(1) : CNT_W'(r.count + 1'b1);
    end

    // read word is formed apart and registered with the ack
    next_r.dat = rd_word;
  end

  // read word: zero for write cycles and unmapped offsets
  always_comb begin
    rd_word = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      if (reg_hit[0]) begin
        rd_word[CBE_CTRL_EN_BIT] = r.enable;
      end else if (reg_hit[1]) begin
        rd_word[CBE_STAT_BUSY_BIT]  = r.busy;
        rd_word[CBE_STAT_TAKEN_BIT] = r.last_taken;
      end else if (reg_hit[2]) begin
        rd_word[PC_W-1:0] = r.last_pc;
      end else if (reg_hit[3]) begin
        rd_word[CNT_W-1:0] = r.count;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r            <= '0;
      r.state      <= CBE_ST_IDLE;
      r.enable     <= CBE_CTRL_EN_RST;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o  = r.ack;
  assign wb_dat_o  = r.dat;
  assign br_busy   = r.busy;
  assign pc_load   = r.load;
  assign pc_value  = r.pc_value;
  assign flags_out = r.flags;

endmodule

// ===== tb/cbe_branch_unit_chk.sv
`timescale 1ns/10ps
module cbe_branch_unit_chk
  import cbe_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        br_req,
  input wire logic [2:0]  br_op,
  input wire logic [6:0]  br_offset,
  input wire logic [15:0] pc_cur,
  input wire logic        flag_c,
  input wire logic        flag_n,
  input wire logic        flag_v,
  input wire logic        flag_h,
  input wire logic        flag_t,
  input wire logic        br_busy,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value,
  input wire logic [4:0]  flags_out,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic [7:0]  cv;
  logic [15:0] tg;
  logic [4:0]  fl;
  logic        go;
  logic        en;
  logic        tk;
  // condition per op code, index is the op
  assign cv = {flag_c, flag_t, !flag_h, flag_h, flag_n ^ flag_v, !(flag_n ^ flag_v), !flag_n, flag_n};
  assign tg = pc_cur + {{9{br_offset[6]}}, br_offset} + 16'h1;
  assign fl = {flag_t, flag_h, flag_v, flag_n, flag_c};
  assign go = br_req && !br_busy;
  assign tk = en && cv[br_op];
  // enable bit as software last wrote it, lane 0 only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en <= CBE_CTRL_EN_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
                 wb_adr_i == CBE_ADR_CTRL) begin
      en <= wb_dat_i[CBE_CTRL_EN_BIT];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_UNTAKEN:
    assert property (go && !tk |=> pc_load && !br_busy && pc_value == $past(pc_cur) + 16'h1)
    else $error("untaken branch wrong");
  AST_TAKEN:
    assert property (go && tk |=> br_busy && !pc_load ##1 pc_load && pc_value == $past(tg, 2))
    else $error("taken branch wrong");
  AST_FLAGS:
    assert property (go |=> flags_out == $past(fl)) else $error("flags changed");
  AST_FLAGS_HOLD:
    assert property (!$past(go) |-> $stable(flags_out)) else $error("flags moved");
  AST_PC_HOLD:
    assert property (!pc_load |-> $stable(pc_value)) else $error("pc moved");
  AST_BUSY_ONE:
    assert property (br_busy |=> !br_busy) else $error("busy too long");
  AST_BUSY_CAUSE:
    assert property (br_busy |-> $past(go) && $past(tk)) else $error("busy uncaused");
  AST_LOAD_CAUSE:
    assert property (pc_load |-> $past(go) || $past(br_busy)) else $error("load uncaused");
endmodule
bind cbe_branch_unit cbe_branch_unit_chk i_cbe_branch_unit_chk (.*);

// ===== tb/cbe_branch_unit_tb.sv
`timescale 1ns/10ps
module cbe_branch_unit_tb
  import cbe_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [3:0]  wb_sel_i = 4'hF;
  logic        br_req = 1'b0, br_busy, pc_load, lasttk;
  logic [2:0]  br_op = 3'h0;
  logic [6:0]  br_offset = 7'h00;
  logic [15:0] pc_cur = 16'h0, pc_value, lastpc;
  logic [4:0]  fl = 5'h00, flags_out;
  logic [20:0] bq[$];
  logic [31:0] rq[$];
  int          mismatches, comparisons, ntk, skip;
  logic        br_en = 1'b1;
  integer      seed = 32'hB97812A9;
  cbe_branch_unit i_cbe_branch_unit (
    .clk_sys, .srst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .br_req, .br_op, .br_offset, .pc_cur, .flag_c(fl[0]),
    .flag_n(fl[1]), .flag_v(fl[2]), .flag_h(fl[3]), .flag_t(fl[4]), .br_busy, .pc_load,
    .pc_value, .flags_out);
  always #4 clk_sys = ~clk_sys;
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_br(input logic [20:0] g, input logic [20:0] e);
    cmp_word({11'h0, g}, {11'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // classic single access, reads note their expected word
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    if (!w) rq.push_back(d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // request held every cycle; the one after a taken branch is refused
  task automatic branches(input int n);
    logic [31:0] r;
    logic [7:0]  cv;
    logic [15:0] pc;
    skip = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      r = $random(seed);
      br_req <= 1'b1;
      br_op <= r[2:0];
      fl <= r[7:3];
      br_offset <= r[14:8];
      pc_cur <= r[30:15];
      if (skip) begin
        skip = 0;
      end else begin
        cv = {r[3], r[7], !r[6], r[6], r[4] ^ r[5], !(r[4] ^ r[5]), !r[4], r[4]};
        lasttk = br_en && cv[r[2:0]];
        pc = r[30:15] + 16'h1 + (lasttk ? {{9{r[14]}}, r[14:8]} : 16'h0);
        bq.push_back({pc, r[7:3]});
        lastpc = pc;
        skip = lasttk;
        ntk += lasttk;
      end
    end
    @(posedge clk_sys);
    br_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (pc_load === 1'b1)
      cmp_br({pc_value, flags_out}, bq.pop_front());
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      cmp_word(wb_dat_o, rq.pop_front());
  end
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    branches(300);
    $display("test branches done");
    wb(CBE_ADR_CTRL, 1'b1, 32'h0);
    br_en = 1'b0;
    branches(40);
    wb(CBE_ADR_CTRL, 1'b1, 32'h1, 4'hE);
    wb(CBE_ADR_CTRL, 1'b0, 32'h0);
    wb(CBE_ADR_CTRL, 1'b1, 32'h1);
    br_en = 1'b1;
    $display("test disabled branches done");
    wb(CBE_ADR_CTRL, 1'b0, 32'h1);
    wb(CBE_ADR_STATUS, 1'b1, 32'hFFFFFFFF);
    wb(CBE_ADR_STATUS, 1'b0, {30'h0, lasttk, 1'b0});
    wb(CBE_ADR_LASTPC, 1'b0, {16'h0, lastpc});
    wb(CBE_ADR_COUNT, 1'b0, ntk);
    wb(CBE_ADR_COUNT, 1'b1, 32'h0);
    wb(CBE_ADR_COUNT, 1'b0, 32'h0);
    wb(8'h10, 1'b1, 32'hFFFFFFFF);
    wb(8'h10, 1'b0, 32'h0);
    @(posedge clk_sys);
    $display("test registers done");
    tally_and_finish();
  end
endmodule
